// ---- src/ppcc_params.svh ----
// Offsets, field positions, reset values and fixed ratios of the clock controller
// How it works
// [R01] Reference clock feeds core, sources all dividers
// [R02] Four output clocks, one divider each
// [R03] First two dividers fixed at three, six
// [R04] Third, fourth ratios set by own registers
// [R05] Software programs multiplier and ratios after reset
// [R06] Hosts wait while clock frequencies change
// [R07] PLL mode: pre-divider then multiplier path
// [R08] Bypass mode: input clock passes straight through
// [R09] Software keeps PLL reference, output in range
// [R10] Software keeps third, fourth clock in range
// [R11] Software waits regulator time before PLL use
// [R12] PLL reset held 128 input periods
// [R13] Lock wait before selecting PLL mode
// [R14] Software leaves unlisted addresses alone
// [R15] Control bits: enable 0, powerdown 1, reset 3
// [R16] Multiplier factor is field value plus one
// [R17] Powerdown bit turns off PLL analog
// [R18] Mode and ratio changes without runt pulses
`ifndef PPCC_PARAMS_SVH
`define PPCC_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PPCC_OFS_CONTROL     32'h029a_0100
`define PPCC_OFS_MULTIPLIER  32'h029a_0110
`define PPCC_OFS_INPUT_PRE_DIVIDER      32'h029a_0114
`define PPCC_OFS_COMMAND     32'h029a_0138
`define PPCC_OFS_STATUS      32'h029a_013c
`define PPCC_OFS_ALIGN       32'h029a_0140
`define PPCC_OFS_DIVIDER_RATIO_CHANGE_STATUS     32'h029a_0144
`define PPCC_OFS_OUTPUT_CLOCK_STATUS      32'h029a_0150
`define PPCC_OFS_DIV4        32'h029a_0160
`define PPCC_OFS_DIV5        32'h029a_0164

// ****************************************
// Field positions
// ****************************************
`define PPCC_CTL_PATH_BIT    0
`define PPCC_CTL_PWRDN_BIT   1
`define PPCC_CTL_RESET_BIT   3
`define PPCC_CTL_ONE_BIT     6
`define PPCC_DIV_EN_BIT      15
`define PPCC_CMD_GO_BIT      0
`define PPCC_STAT_BUSY_BIT   0
`define PPCC_DIV4_BIT        3
`define PPCC_DIV5_BIT        4

// ****************************************
// Reset values and fixed ratios
// ****************************************
`define PPCC_RST_CONTROL     32'h0000_0048
`define PPCC_RST_MULT        5'h00
`define PPCC_RST_INPUT_PRE_DIVIDER      5'h02
`define PPCC_RST_DIV_RATIO   5'h00
`define PPCC_FIX_RATIO_FAB   5'h02
`define PPCC_FIX_RATIO_PER   5'h05

`endif

// ---- src/ppcc_pkg.sv ----
// Types shared by the clock controller modules
package ppcc_pkg;
   typedef logic [4:0] ppcc_ratio_t;
   typedef enum logic [1:0] {
      PPCC_IDLE   = 2'b00,
      PPCC_ARMED  = 2'b01,
      PPCC_ALIGN  = 2'b10
   } ppcc_go_state_t;
endpackage

// ---- src/ppcc_div_if.sv ----
// Bundle between the controller and one clock divider
`timescale 1ns/1ps
interface ppcc_div_if;
   logic                 refTick;
   ppcc_pkg::ppcc_ratio_t ratio;
   logic                 enable;
   logic                 outClk;
   logic                 wrap;
   logic                 ratioTaken;
   modport ctrl (output refTick, output ratio, output enable,
                 input outClk, input wrap, input ratioTaken);
   modport div  (input refTick, input ratio, input enable,
                 output outClk, output wrap, output ratioTaken);
endinterface

// ---- src/ppcc_clk_divider.sv ----
// Divide-by-(ratio+1) clock divider that takes new ratios only at its wrap
`timescale 1ns/1ps
module ppcc_clk_divider #(
   parameter int WIDTH = 5
) (
   input  wire logic sys_clk,
   input  wire logic rstn,
   ppcc_div_if.div   dv
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] ratio_reg;
   logic             clk_reg;
   logic             atEnd;

   assign atEnd = (count_reg == ratio_reg);
   assign dv.wrap = dv.refTick & atEnd;
   assign dv.outClk = clk_reg;
   assign dv.ratioTaken = dv.wrap;

   // ****************************************
   // Counter and ratio reload
   // ****************************************
   // New ratio only at the period boundary, so no short high or low phase
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         count_reg <= '0;
         ratio_reg <= '0;
      end else if (dv.refTick) begin
         if (atEnd) begin
            count_reg <= '0;
            ratio_reg <= dv.ratio; // R18
         end else begin
            count_reg <= count_reg + WIDTH'(1);
         end
      end
   end

   // High for the first half period; even ratios (odd divide-by) give the extra tick to high
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         clk_reg <= 1'b0;
      end else if (!dv.enable) begin
         clk_reg <= 1'b0;
      end else if (dv.refTick) begin
         if (atEnd) begin
            clk_reg <= 1'b1; // R02
         end else begin
            // Rises only at the wrap, so enabling mid-period gives no short pulse
            clk_reg <= clk_reg & ((count_reg + WIDTH'(1)) <= (ratio_reg >> 1));
         end
      end
   end
endmodule

// ---- src/ppcc_top.sv ----
// Primary PLL clock controller: register bank, mode select and four dividers
`timescale 1ns/1ps
`include "ppcc_params.svh"
module ppcc_top (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic [31:0] regAddr,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [31:0] regWdata,
   output logic      [31:0] regRdata,
   output logic             regRdValid,
   input  wire logic        pllClockTick,
   output logic             pllResetOut,
   output logic             pllPowerdownOut,
   output logic      [5:0]  pllMultiplyFactor,
   output logic      [5:0]  inputPreDivide,
   output logic             inputPreDivEnable,
   output logic             systemReferenceTick,
   output logic             fabricClock,
   output logic             peripheralClock,
   output logic             memoryIfInternalClock,
   output logic             emulationClock,
   output logic             hostHoldOff
);
   localparam int NDIV = 4;

   logic [31:0]               control_reg;
   ppcc_pkg::ppcc_ratio_t     mult_reg;
   ppcc_pkg::ppcc_ratio_t     input_pre_divider_reg;
   logic                      predivEn_reg;
   ppcc_pkg::ppcc_ratio_t     div4Ratio_reg;
   ppcc_pkg::ppcc_ratio_t     div5Ratio_reg;
   logic                      div4En_reg;
   logic                      div5En_reg;
   logic [1:0]                align_reg;
   logic [1:0]                divider_ratio_change_status_reg;
   ppcc_pkg::ppcc_ratio_t     applied4_reg;
   ppcc_pkg::ppcc_ratio_t     applied5_reg;
   ppcc_pkg::ppcc_go_state_t  go_reg;
   ppcc_pkg::ppcc_go_state_t  go_next;
   logic                      pathActive_reg;
   logic                      tickMeta_reg;
   logic                      tickSync_reg;
   logic                      tickLast_reg;
   logic                      pllTick;
   logic                      wrEn;
   logic                      goCmd;
   logic                      allWrapped;
   logic [31:0]               readMux;
   logic [NDIV-1:0]           wraps;
   logic [NDIV-1:0]           outClks;
   logic [NDIV-1:0]           takes;
   logic [NDIV-1:0]           taken_reg;

   ppcc_div_if divBus [NDIV] ();

   assign wrEn = regWrite;
   assign goCmd = wrEn && (regAddr == `PPCC_OFS_COMMAND) && regWdata[`PPCC_CMD_GO_BIT];

   // ****************************************
   // Register writes
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         control_reg <= `PPCC_RST_CONTROL; // R15
      end else if (wrEn && regAddr == `PPCC_OFS_CONTROL) begin
         control_reg <= 32'h0000_0000;
         control_reg[`PPCC_CTL_ONE_BIT] <= 1'b1;
         control_reg[`PPCC_CTL_PATH_BIT] <= regWdata[`PPCC_CTL_PATH_BIT]; // R15
         control_reg[`PPCC_CTL_PWRDN_BIT] <= regWdata[`PPCC_CTL_PWRDN_BIT];
         control_reg[`PPCC_CTL_RESET_BIT] <= regWdata[`PPCC_CTL_RESET_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         mult_reg <= `PPCC_RST_MULT;
         input_pre_divider_reg <= `PPCC_RST_INPUT_PRE_DIVIDER;
         predivEn_reg <= 1'b1;
         align_reg <= 2'b00;
      end else if (wrEn) begin
         if (regAddr == `PPCC_OFS_MULTIPLIER) begin
            mult_reg <= regWdata[4:0];
         end
         if (regAddr == `PPCC_OFS_INPUT_PRE_DIVIDER) begin
            input_pre_divider_reg <= regWdata[4:0];
            predivEn_reg <= regWdata[`PPCC_DIV_EN_BIT];
         end
         if (regAddr == `PPCC_OFS_ALIGN) begin
            align_reg <= {regWdata[`PPCC_DIV5_BIT], regWdata[`PPCC_DIV4_BIT]};
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         div4Ratio_reg <= `PPCC_RST_DIV_RATIO;
         div5Ratio_reg <= `PPCC_RST_DIV_RATIO;
         div4En_reg <= 1'b1;
         div5En_reg <= 1'b1;
      end else if (wrEn) begin
         if (regAddr == `PPCC_OFS_DIV4) begin
            div4Ratio_reg <= regWdata[4:0]; // R04
            div4En_reg <= regWdata[`PPCC_DIV_EN_BIT];
         end
         if (regAddr == `PPCC_OFS_DIV5) begin
            div5Ratio_reg <= regWdata[4:0]; // R04
            div5En_reg <= regWdata[`PPCC_DIV_EN_BIT];
         end
      end
   end

   // Pending-change flags: a new write wins over the clear at GO completion
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         divider_ratio_change_status_reg <= 2'b00;
      end else begin
         divider_ratio_change_status_reg[0] <= (wrEn && regAddr == `PPCC_OFS_DIV4 &&
                            regWdata[4:0] != applied4_reg) ||
                           (divider_ratio_change_status_reg[0] && !(go_reg == ppcc_pkg::PPCC_ALIGN && allWrapped));
         divider_ratio_change_status_reg[1] <= (wrEn && regAddr == `PPCC_OFS_DIV5 &&
                            regWdata[4:0] != applied5_reg) ||
                           (divider_ratio_change_status_reg[1] && !(go_reg == ppcc_pkg::PPCC_ALIGN && allWrapped));
      end
   end

   // ****************************************
   // GO sequence: ratios move to dividers together
   // ****************************************
   // Each enabled divider must have reloaded once; waiting for one common
   // edge of all four could starve when their periods never line up
   always_ff @(posedge sys_clk) begin
      if (!rstn || go_reg != ppcc_pkg::PPCC_ALIGN) begin
         taken_reg <= '0;
      end else begin
         taken_reg <= taken_reg | takes;
      end
   end
   assign allWrapped = &(taken_reg | takes | ~{div5En_reg, div4En_reg, 2'b11});

   always_comb begin
      go_next = go_reg;
      case (go_reg)
         ppcc_pkg::PPCC_IDLE: begin
            if (goCmd) begin
               go_next = ppcc_pkg::PPCC_ARMED;
            end
         end
         ppcc_pkg::PPCC_ARMED: begin
            go_next = ppcc_pkg::PPCC_ALIGN;
         end
         ppcc_pkg::PPCC_ALIGN: begin
            if (allWrapped) begin
               go_next = ppcc_pkg::PPCC_IDLE;
            end
         end
         default: begin
            go_next = ppcc_pkg::PPCC_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         go_reg <= ppcc_pkg::PPCC_IDLE;
         applied4_reg <= `PPCC_RST_DIV_RATIO;
         applied5_reg <= `PPCC_RST_DIV_RATIO;
      end else begin
         go_reg <= go_next;
         if (go_reg == ppcc_pkg::PPCC_ARMED) begin
            if (divider_ratio_change_status_reg[0] || align_reg[0]) begin
               applied4_reg <= div4Ratio_reg; // R04
            end
            if (divider_ratio_change_status_reg[1] || align_reg[1]) begin
               applied5_reg <= div5Ratio_reg;
            end
         end
      end
   end

   // ****************************************
   // Reference clock source and mode switch
   // ****************************************
   // PLL output arrives from the analog macro; the edge is decoded from the second and third flops
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         tickMeta_reg <= 1'b0;
         tickSync_reg <= 1'b0;
         tickLast_reg <= 1'b0;
      end else begin
         tickMeta_reg <= pllClockTick;
         tickSync_reg <= tickMeta_reg;
         tickLast_reg <= tickSync_reg;
      end
   end
   assign pllTick = tickSync_reg & ~tickLast_reg;

   // Path swaps only at a fabric divider boundary so no output sees a runt
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         pathActive_reg <= 1'b0; // R08
      end else if (wraps[0] || !pathActive_reg && !control_reg[`PPCC_CTL_PATH_BIT]) begin
         pathActive_reg <= control_reg[`PPCC_CTL_PATH_BIT]; // R18
      end
   end

   // Bypass: every input clock edge is a reference edge; PLL: macro output
   assign systemReferenceTick = pathActive_reg ? pllTick : 1'b1; // R07 R08 R01

   assign pllResetOut = control_reg[`PPCC_CTL_RESET_BIT];
   assign pllPowerdownOut = control_reg[`PPCC_CTL_PWRDN_BIT]; // R17
   assign pllMultiplyFactor = {1'b0, mult_reg} + 6'h01; // R16
   assign inputPreDivide = {1'b0, input_pre_divider_reg} + 6'h01; // R07
   assign inputPreDivEnable = predivEn_reg;
   // Host held off while ratios or the reference path are in motion
   assign hostHoldOff = (go_reg != ppcc_pkg::PPCC_IDLE) || goCmd ||
                        (pathActive_reg != control_reg[`PPCC_CTL_PATH_BIT]); // R06

   // ****************************************
   // Dividers
   // ****************************************
   generate
      for (genvar i = 0; i < NDIV; i++) begin : gDiv
         assign divBus[i].refTick = systemReferenceTick; // R01
         assign wraps[i] = divBus[i].wrap;
         assign takes[i] = divBus[i].ratioTaken;
         assign outClks[i] = divBus[i].outClk;
         if (i == 0) begin : gFab
            assign divBus[i].ratio = `PPCC_FIX_RATIO_FAB; // R03
            assign divBus[i].enable = 1'b1;
         end else if (i == 1) begin : gPer
            assign divBus[i].ratio = `PPCC_FIX_RATIO_PER; // R03
            assign divBus[i].enable = 1'b1;
         end else if (i == 2) begin : gMem
            assign divBus[i].ratio = applied4_reg;
            assign divBus[i].enable = div4En_reg;
         end else begin : gEmu
            assign divBus[i].ratio = applied5_reg;
            assign divBus[i].enable = div5En_reg;
         end
         ppcc_clk_divider #(.WIDTH(5)) uDiv (
            .sys_clk (sys_clk),
            .rstn    (rstn),
            .dv      (divBus[i])
         );
      end
   endgenerate

   assign fabricClock = outClks[0]; // R02
   assign peripheralClock = outClks[1];
   assign memoryIfInternalClock = outClks[2];
   assign emulationClock = outClks[3];

   // ****************************************
   // Register reads
   // ****************************************
   always_comb begin
      readMux = 32'h0000_0000;
      case (regAddr)
         `PPCC_OFS_CONTROL:    readMux = control_reg;
         `PPCC_OFS_MULTIPLIER: readMux = {27'h0, mult_reg};
         `PPCC_OFS_INPUT_PRE_DIVIDER:     readMux = {16'h0, predivEn_reg, 10'h0, input_pre_divider_reg};
         `PPCC_OFS_STATUS:     readMux = {31'h0, go_reg != ppcc_pkg::PPCC_IDLE};
         `PPCC_OFS_ALIGN:      readMux = {27'h0, align_reg, 3'h0};
         `PPCC_OFS_DIVIDER_RATIO_CHANGE_STATUS:    readMux = {27'h0, divider_ratio_change_status_reg, 3'h0};
         `PPCC_OFS_OUTPUT_CLOCK_STATUS:     readMux = {27'h0, outClks, 1'b0};
         `PPCC_OFS_DIV4:       readMux = {16'h0, div4En_reg, 10'h0, div4Ratio_reg};
         `PPCC_OFS_DIV5:       readMux = {16'h0, div5En_reg, 10'h0, div5Ratio_reg};
         default:              readMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         regRdata <= 32'h0000_0000;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRead;
         if (regRead) begin
            regRdata <= readMux;
         end
      end
   end
endmodule

// ---- verif/ppcc_top_props.sv ----
// Assertions on the clock controller top ports
`timescale 1ns/1ps
`include "ppcc_params.svh"
module ppcc_top_props (
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic [31:0] regAddr,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [31:0] regWdata,
   input wire logic [31:0] regRdata,
   input wire logic        regRdValid,
   input wire logic        pllResetOut,
   input wire logic        pllPowerdownOut,
   input wire logic [5:0]  pllMultiplyFactor,
   input wire logic        systemReferenceTick,
   input wire logic        fabricClock,
   input wire logic        peripheralClock,
   input wire logic        hostHoldOff
);
   logic       pathReq_reg;
   logic [3:0] steady_reg;
   logic [4:0] fabGap_reg;
   logic [4:0] perGap_reg;
   logic       ctlWr;
   logic [4:0] multIn;
   logic [1:0] ctlBits;
   assign ctlWr = regWrite && regAddr == `PPCC_OFS_CONTROL;
   assign multIn = regWdata[4:0];
   assign ctlBits = {regWdata[3], regWdata[1]};
   // *****
   // Helpers
   // *****
   always_ff @(posedge sys_clk) begin
      if (!rstn) pathReq_reg <= 1'b0;
      else if (ctlWr) pathReq_reg <= regWdata[0];
   end
   // Gaps judged only in settled bypass, a switch may stretch a period
   always_ff @(posedge sys_clk) begin
      if (!rstn || hostHoldOff || pathReq_reg) steady_reg <= 4'h0;
      else if (steady_reg != 4'hf) steady_reg <= steady_reg + 4'h1;
   end
   always_ff @(posedge sys_clk) begin
      if (!rstn || $rose(fabricClock)) fabGap_reg <= 5'h01;
      else if (fabGap_reg != 5'h1f) fabGap_reg <= fabGap_reg + 5'h01;
   end
   always_ff @(posedge sys_clk) begin
      if (!rstn || $rose(peripheralClock)) perGap_reg <= 5'h01;
      else if (perGap_reg != 5'h1f) perGap_reg <= perGap_reg + 5'h01;
   end
   // *****
   // Properties
   // *****
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   property p_read_answer;
      regRead |=> regRdValid;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered");
   property p_unmapped;
      regRead && regAddr == 32'h029a_0104 |=> regRdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_mult;
      regWrite && regAddr == `PPCC_OFS_MULTIPLIER |=>
         pllMultiplyFactor == {1'b0, $past(multIn)} + 6'h01;
   endproperty
   a_mult: assert property (p_mult) else $error("multiply factor wrong");
   property p_ctl;
      ctlWr |=> {pllResetOut, pllPowerdownOut} == $past(ctlBits);
   endproperty
   a_ctl: assert property (p_ctl) else $error("control outputs wrong");
   property p_bypass;
      !pathReq_reg && !hostHoldOff |-> systemReferenceTick;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass tick missing");
   property p_fab;
      $rose(fabricClock) && steady_reg >= 4'ha |-> fabGap_reg == 5'h03;
   endproperty
   a_fab: assert property (p_fab) else $error("fabric period wrong");
   property p_per;
      $rose(peripheralClock) && steady_reg >= 4'ha |-> perGap_reg == 5'h06;
   endproperty
   a_per: assert property (p_per) else $error("peripheral period wrong");
   property p_go;
      regWrite && regAddr == `PPCC_OFS_COMMAND && regWdata[0] && !hostHoldOff
         |=> hostHoldOff;
   endproperty
   a_go: assert property (p_go) else $error("hold-off not raised");
   property p_hold_end;
      $rose(hostHoldOff) |-> ##[1:1000] !hostHoldOff;
   endproperty
   a_hold_end: assert property (p_hold_end) else $error("hold-off stuck");
endmodule
bind ppcc_top ppcc_top_props u_props (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
   .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
   .regRdValid(regRdValid), .pllResetOut(pllResetOut), .pllPowerdownOut(pllPowerdownOut),
   .pllMultiplyFactor(pllMultiplyFactor), .systemReferenceTick(systemReferenceTick),
   .fabricClock(fabricClock), .peripheralClock(peripheralClock), .hostHoldOff(hostHoldOff));

// ---- verif/ppcc_testbench.sv ----
// Self-checking bench for the clock controller top
`timescale 1ns/1ps
`include "ppcc_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH %0t got %0h exp %0h", $time, (g), (e)); end end
module testbench;
   logic        sys_clk, rstn, regWrite, regRead, regRdValid, pllClockTick, tickOn;
   logic [31:0] regAddr, regWdata, regRdata, seed, d;
   logic [5:0]  pllMultiplyFactor, inputPreDivide;
   logic        pllResetOut, pllPowerdownOut, inputPreDivEnable, systemReferenceTick;
   logic        fabricClock, peripheralClock, memoryIfInternalClock, emulationClock;
   logic        hostHoldOff;
   logic [3:0]  clks;
   logic [1:0]  tickCnt;
   logic [4:0]  r, prv;
   int          err_count, check_count;
   assign clks = {emulationClock, memoryIfInternalClock, peripheralClock, fabricClock};
   ppcc_top dut (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWrite(regWrite),
      .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
      .pllClockTick(pllClockTick), .pllResetOut(pllResetOut),
      .pllPowerdownOut(pllPowerdownOut), .pllMultiplyFactor(pllMultiplyFactor),
      .inputPreDivide(inputPreDivide), .inputPreDivEnable(inputPreDivEnable),
      .systemReferenceTick(systemReferenceTick), .fabricClock(fabricClock),
      .peripheralClock(peripheralClock), .memoryIfInternalClock(memoryIfInternalClock),
      .emulationClock(emulationClock), .hostHoldOff(hostHoldOff));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // PLL output stand-in: one rising edge every 4 system cycles
   always @(negedge sys_clk) begin
      tickCnt <= tickOn ? tickCnt + 2'h1 : 2'h0;
      pllClockTick <= tickOn & tickCnt[1];
   end
   // *****
   // Helpers
   // *****
   function automatic logic [31:0] nxt(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0000_0000);
   endfunction
   function automatic logic [5:0] mulx(input logic [31:0] x);
      return {1'b0, x[4:0]} + 6'h01;
   endfunction
   task automatic complete_run;
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(negedge sys_clk);
      regAddr = a;
      regWdata = v;
      regWrite = 1'b1;
      @(negedge sys_clk);
      regWrite = 1'b0;
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] e);
      @(negedge sys_clk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge sys_clk);
      regRead = 1'b0;
      `CHK(regRdValid, 1'b1)
      `CHK(regRdata, e)
   endtask
   task automatic settle;
      int n;
      n = 0;
      @(negedge sys_clk);
      while (hostHoldOff !== 1'b0 && n < 2000) begin
         @(negedge sys_clk);
         n++;
      end
      `CHK(hostHoldOff, 1'b0)
   endtask
   // Cycles between two rising edges of one output clock
   task automatic per(input int i, input int e);
      logic pv;
      int   n, c, s;
      pv = clks[i];
      n = 0;
      c = 0;
      s = 0;
      while (n < 2 && c < 3000) begin
         @(posedge sys_clk);
         #1;
         c++;
         if (pv === 1'b0 && clks[i] === 1'b1) begin
            n++;
            if (n == 1) s = c;
         end
         pv = clks[i];
      end
      `CHK(c - s, e)
   endtask
   initial begin
      repeat (50000) @(posedge sys_clk);
      err_count++;
      complete_run;
   end
   // *****
   // Main sequence
   // *****
   initial begin
      seed = 32'hf446_b08a;
      {rstn, regWrite, regRead, tickOn} = 4'h0;
      regAddr = '0;
      regWdata = '0;
      err_count = 0;
      check_count = 0;
      prv = 5'h00;
      repeat (20) @(negedge sys_clk);
      rstn = 1'b1;
      `CHK(pllResetOut, 1'b1)
      `CHK(systemReferenceTick, 1'b1)
      rchk(`PPCC_OFS_CONTROL, 32'h0000_0048);
      rchk(`PPCC_OFS_DIV4, 32'h0000_8000);
      rchk(32'h029a_0104, 32'h0000_0000);
      rchk(`PPCC_OFS_INPUT_PRE_DIVIDER, 32'h0000_8002);
      `CHK(inputPreDivide, 6'h03)
      per(0, 3);
      per(1, 6);
      for (int i = 0; i < 10; i++) begin
         seed = nxt(seed);
         d = (i == 0) ? 32'h0000_0013 : (i == 1) ? 32'h0000_001f : seed;
         wr(`PPCC_OFS_MULTIPLIER, d);
         rchk(`PPCC_OFS_MULTIPLIER, d & 32'h0000_001f);
         `CHK(pllMultiplyFactor, mulx(d))
         wr(`PPCC_OFS_INPUT_PRE_DIVIDER, d);
         rchk(`PPCC_OFS_INPUT_PRE_DIVIDER, d & 32'h0000_801f);
         `CHK(inputPreDivide, mulx(d))
         `CHK(inputPreDivEnable, d[15])
      end
      for (int i = 0; i < 6; i++) begin
         seed = nxt(seed);
         d = seed & 32'h0000_000a;
         wr(`PPCC_OFS_CONTROL, d);
         rchk(`PPCC_OFS_CONTROL, d | 32'h0000_0040);
         `CHK(pllPowerdownOut, d[1])
         `CHK(pllResetOut, d[3])
      end
      wr(`PPCC_OFS_CONTROL, 32'h0000_0000);
      for (int i = 0; i < 3; i++) begin
         seed = nxt(seed);
         r = {3'h0, seed[1:0]} + 5'h01;
         wr(`PPCC_OFS_DIV4, 32'h0000_8000 | r);
         wr(`PPCC_OFS_DIV5, 32'h0000_8003);
         d = ((r != prv) ? 32'h0000_0008 : 32'h0) | ((i == 0) ? 32'h0000_0010 : 32'h0);
         rchk(`PPCC_OFS_DIVIDER_RATIO_CHANGE_STATUS, d);
         wr(`PPCC_OFS_COMMAND, 32'h0000_0001);
         @(negedge sys_clk);
         `CHK(hostHoldOff, 1'b1)
         settle;
         rchk(`PPCC_OFS_STATUS, 32'h0000_0000);
         rchk(`PPCC_OFS_DIVIDER_RATIO_CHANGE_STATUS, 32'h0000_0000);
         per(2, int'(r) + 1);
         per(3, 4);
         prv = r;
      end
      wr(`PPCC_OFS_ALIGN, 32'h0000_0018);
      rchk(`PPCC_OFS_ALIGN, 32'h0000_0018);
      wr(`PPCC_OFS_COMMAND, 32'h0000_0001);
      settle;
      rchk(`PPCC_OFS_DIVIDER_RATIO_CHANGE_STATUS, 32'h0000_0000);
      per(2, int'(prv) + 1);
      // Disabled dividers park low; the fixed pair cannot be switched off
      wr(`PPCC_OFS_DIV4, {27'h0, prv});
      wr(`PPCC_OFS_DIV5, 32'h0000_0003);
      @(negedge sys_clk);
      regAddr = `PPCC_OFS_OUTPUT_CLOCK_STATUS;
      regRead = 1'b1;
      @(negedge sys_clk);
      regRead = 1'b0;
      `CHK(regRdata & 32'hffff_ff19, 32'h0000_0000)
      `CHK({emulationClock, memoryIfInternalClock}, 2'b00)
      wr(`PPCC_OFS_DIV4, 32'h0000_8000 | prv);
      wr(`PPCC_OFS_DIV5, 32'h0000_8003);
      per(3, 4);
      // Bring-up order for the PLL: settle time, reset pulse, lock wait
      wr(`PPCC_OFS_MULTIPLIER, 32'h0000_0013);
      wr(`PPCC_OFS_INPUT_PRE_DIVIDER, 32'h0000_8004);
      while ($time < 150000) @(negedge sys_clk);
      wr(`PPCC_OFS_CONTROL, 32'h0000_0008);
      repeat (128) @(negedge sys_clk);
      wr(`PPCC_OFS_CONTROL, 32'h0000_0000);
      repeat (2000) @(negedge sys_clk);
      tickOn = 1'b1;
      wr(`PPCC_OFS_CONTROL, 32'h0000_0001);
      settle;
      per(0, 12);
      per(1, 24);
      wr(`PPCC_OFS_CONTROL, 32'h0000_0000);
      settle;
      `CHK(systemReferenceTick, 1'b1)
      per(0, 3);
      // Reset again while the PLL stand-in still ticks
      @(negedge sys_clk);
      rstn = 1'b0;
      repeat (3) @(negedge sys_clk);
      rstn = 1'b1;
      `CHK(systemReferenceTick, 1'b1)
      rchk(`PPCC_OFS_CONTROL, 32'h0000_0048);
      rchk(`PPCC_OFS_DIV4, 32'h0000_8000);
      complete_run;
   end
endmodule
